// ---- logic/dsm_regs.sv ----
// register bank of the drive serial slave: commands and monitors
`timescale 1ns/10ps
`include "dsm_map.svh"

// Behaviour
// - command and reference registers accept writes
// - op bit 0 runs, cleared stops
// - op bit 1 reverse, cleared forward
// - op bit 4 raises external fault
// - op bit 5 issues fault reset
// - op bits C..F drive inputs five..eight
// - undefined op bits use local data
// - error details latch until fault reset
// - fault reset clears even while running
// - status bit 1 shows contact output two
// - status bit 2 shows contact output three
// - status bit 3 shows photocoupler output three
// - feedback unsigned, ten counts per percent
// - pid in/out signed, ten per percent
module dsm_regs
	import dsm_pkg::*;
(
	input  logic        i_clock,
	input  logic        i_srst,
	// register access port
	input  logic        i_reg_sel,
	input  logic        i_reg_write,
	input  logic [15:0] i_reg_addr,
	input  logic [15:0] i_reg_wdata,
	output logic [15:0] o_reg_rdata,
	output logic        o_reg_done,
	output logic [1:0]  o_reg_resp,
	// local node operation data
	input  logic [15:0] i_local_cmd,
	// terminal pins, asynchronous
	input  logic        i_contact_out_one,
	input  logic        i_contact_out_two,
	input  logic        i_contact_out_three,
	input  logic        i_photocoupler_out_three,
	input  logic        i_photocoupler_out_four,
	input  logic        i_fault_reset_pin,
	// monitor quantities, same clock
	input  logic [15:0] i_dc_bus_voltage,
	input  logic [15:0] i_torque,
	input  logic [15:0] i_output_power_monitor,
	input  logic [15:0] i_pid_feedback,
	input  logic [15:0] i_pid_input,
	input  logic [15:0] i_pid_output,
	input  logic [15:0] i_cpu_version,
	input  logic [15:0] i_flash_version,
	input  logic [15:0] i_power_rating,
	input  logic [15:0] i_control_scheme,
	// link error events, one-cycle pulses
	input  logic        i_crc_err,
	input  logic        i_len_err,
	input  logic        i_parity_err,
	input  logic        i_overrun_err,
	input  logic        i_framing_err,
	input  logic        i_timeout_err,
	// drive command outputs
	output logic        o_run,
	output logic        o_reverse,
	output logic        o_ext_fault,
	output logic        o_fault_reset,
	output logic [3:0]  o_multi_inputs,
	output logic [15:0] o_effective_cmd,
	output logic [15:0] o_freq_ref_pct,
	output logic [15:0] o_link_error_details
);

	////////////////////////////////////////////////////////////////
	// declarations

	dsm_word_t   op_cmd_q;        // operation command word
	dsm_word_t   freq_ref_q;      // speed reference word
	dsm_word_t   eff_cmd_d;       // merged command word
	dsm_word_t   freq_sat;        // reference clipped to full scale
	dsm_word_t   freq_pct_d;      // reference in tenths of percent
	dsm_word_t   rdata_d;         // read mux result
	dsm_resp_t   resp_d;          // access answer
	logic [5:0]  pins_raw;        // pins before sync
	logic [5:0]  pins_s;          // pins after sync
	logic        hit_op;          // address decodes
	logic        hit_freq;
	logic        wr_op;           // accepted writes
	logic        wr_freq;
	logic        flt_rst;         // combined fault reset
	dsm_err_if   err_bus ();      // error latch carrier

	////////////////////////////////////////////////////////////////
	// saturation helpers

	// clip a signed value to plus or minus full scale
	function automatic dsm_word_t sat_signed(input dsm_word_t v);
		dsm_word_t r;
		r = v;
		if ($signed(v) > $signed(`DSM_PCT_POS)) begin
			r = `DSM_PCT_POS;
		end else if ($signed(v) < $signed(`DSM_PCT_NEG)) begin
			r = `DSM_PCT_NEG;
		end
		return r;
	endfunction : sat_signed

	// clip to zero..full scale, negative reads as zero
	function automatic dsm_word_t sat_unsigned(input dsm_word_t v);
		dsm_word_t r;
		r = v;
		if (v[15]) begin
			r = 16'h0000;
		end else if (v > `DSM_PCT_POS) begin
			r = `DSM_PCT_POS;
		end
		return r;
	endfunction : sat_unsigned

	////////////////////////////////////////////////////////////////
	// pin synchronisers

	// gather pins in bit order of the status word
	assign pins_raw = {
		i_fault_reset_pin,
		i_photocoupler_out_four,
		i_photocoupler_out_three,
		i_contact_out_three,
		i_contact_out_two,
		i_contact_out_one
	};

	// two flops before any logic looks at a pin
	dsm_sync #(
		.WIDTH (6)
	) u_sync (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.i_async (pins_raw),
		.o_sync  (pins_s)
	);

	////////////////////////////////////////////////////////////////
	// address decode and write strobes

	// only the two broadcast words take writes
	assign hit_op   = (i_reg_addr == `DSM_ADDR_OP_CMD);
	assign hit_freq = (i_reg_addr == `DSM_ADDR_FREQ_REF);
	assign wr_op    = i_reg_sel & i_reg_write & hit_op;
	assign wr_freq  = i_reg_sel & i_reg_write & hit_freq;

	////////////////////////////////////////////////////////////////
	// broadcast command registers

	// operation command word, all sixteen bits stored
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			op_cmd_q <= `DSM_RST_OP_CMD;
		end else if (wr_op) begin
			op_cmd_q <= i_reg_wdata;
		end
	end

	// speed reference word, raw counts
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			freq_ref_q <= `DSM_RST_FREQ_REF;
		end else if (wr_freq) begin
			freq_ref_q <= i_reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// command merge with local node data

	// defined bits from broadcast, the rest local
	always_comb begin
		eff_cmd_d = (op_cmd_q & `DSM_OP_DEF_MASK)
			| (i_local_cmd & ~`DSM_OP_DEF_MASK);
	end

	// registered command outputs
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_run           <= 1'b0;
			o_reverse       <= 1'b0;
			o_ext_fault     <= 1'b0;
			o_multi_inputs  <= 4'h0;
			o_effective_cmd <= 16'h0000;
		end else begin
			o_run           <= eff_cmd_d[`DSM_BIT_RUN];
			o_reverse       <= eff_cmd_d[`DSM_BIT_REVERSE];
			o_ext_fault     <= eff_cmd_d[`DSM_BIT_EXT_FLT];
			o_multi_inputs  <= eff_cmd_d[`DSM_BIT_MI_EIGHT:`DSM_BIT_MI_FIVE];
			o_effective_cmd <= eff_cmd_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// fault reset

	// command bit or the synchronised pin
	// fault reset command
	assign flt_rst = eff_cmd_d[`DSM_BIT_FLT_RST] | pins_s[5];

	// fault reset level out to the drive
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_fault_reset <= 1'b0;
		end else begin
			o_fault_reset <= flt_rst;
		end
	end

	////////////////////////////////////////////////////////////////
	// frequency reference scaling

	// clip at full scale, then to tenths of percent
	always_comb begin
		freq_sat = freq_ref_q;
		if (freq_ref_q > `DSM_FREF_FULL) begin
			freq_sat = `DSM_FREF_FULL;
		end
		freq_pct_d = freq_sat / `DSM_FREF_DIV;
	end

	// scaled reference register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_freq_ref_pct <= 16'h0000;
		end else begin
			o_freq_ref_pct <= freq_pct_d;
		end
	end

	////////////////////////////////////////////////////////////////
	// communications error details

	// event vector in detail-bit order, unused bits idle
	always_comb begin
		err_bus.evt = 16'h0000;
		err_bus.evt[`DSM_ERR_CRC] = i_crc_err;
		err_bus.evt[`DSM_ERR_LEN] = i_len_err;
		err_bus.evt[`DSM_ERR_PAR] = i_parity_err;
		err_bus.evt[`DSM_ERR_OVR] = i_overrun_err;
		err_bus.evt[`DSM_ERR_FRM] = i_framing_err;
		err_bus.evt[`DSM_ERR_TMO] = i_timeout_err;
	end

	assign err_bus.clr = flt_rst;

	dsm_err_latch u_err (
		.i_clock (i_clock),
		.i_srst  (i_srst),
		.err     (err_bus.sink)
	);

	// error details mirrored to a port
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_link_error_details <= 16'h0000;
		end else begin
			o_link_error_details <= err_bus.detail;
		end
	end

	////////////////////////////////////////////////////////////////
	// read mux and answer

	// select data and answer for the addressed word
	always_comb begin
		rdata_d = 16'h0000;
		resp_d  = DSM_RESP_READ_ONLY;
		case (i_reg_addr)
			`DSM_ADDR_OP_CMD: begin
				rdata_d = op_cmd_q;
				resp_d  = DSM_RESP_OK;
			end
			`DSM_ADDR_FREQ_REF: begin
				rdata_d = freq_ref_q;
				resp_d  = DSM_RESP_OK;
			end
			`DSM_ADDR_OUT_STAT: begin
				rdata_d[4:0] = pins_s[4:0];
			end
			`DSM_ADDR_DC_BUS: begin
				rdata_d = i_dc_bus_voltage;
			end
			`DSM_ADDR_TORQUE: begin
				rdata_d = i_torque;
			end
			`DSM_ADDR_OUT_PWR: begin
				rdata_d = i_output_power_monitor;
			end
			`DSM_ADDR_PID_FB: begin
				rdata_d = sat_unsigned(i_pid_feedback);
			end
			`DSM_ADDR_PID_IN: begin
				rdata_d = sat_signed(i_pid_input);
			end
			`DSM_ADDR_PID_OUT: begin
				rdata_d = sat_signed(i_pid_output);
			end
			`DSM_ADDR_CPU_VER: begin
				rdata_d = i_cpu_version;
			end
			`DSM_ADDR_FLASH: begin
				rdata_d = i_flash_version;
			end
			`DSM_ADDR_ERR: begin
				rdata_d = err_bus.detail;
			end
			`DSM_ADDR_KVA: begin
				rdata_d = i_power_rating;
			end
			`DSM_ADDR_CTRL: begin
				rdata_d = i_control_scheme;
			end
			default: begin
				// unmapped word
				resp_d = DSM_RESP_BAD_ADDR;
			end
		endcase
		// a read of any mapped word is fine
		if (!i_reg_write && resp_d == DSM_RESP_READ_ONLY) begin
			resp_d = DSM_RESP_OK;
		end
	end

	// answer one cycle after the select
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_reg_rdata <= 16'h0000;
			o_reg_done  <= 1'b0;
			o_reg_resp  <= DSM_RESP_OK;
		end else begin
			o_reg_done <= i_reg_sel;
			if (i_reg_sel) begin
				// writes return no data
				o_reg_rdata <= i_reg_write ? 16'h0000 : rdata_d;
				o_reg_resp  <= resp_d;
			end
		end
	end

endmodule : dsm_regs

// ---- logic/dsm_map.svh ----
// register offsets, field positions, reset values and scale constants
`ifndef DSM_MAP_SVH
`define DSM_MAP_SVH

// writable broadcast registers
`define DSM_ADDR_OP_CMD   16'h0001
`define DSM_ADDR_FREQ_REF 16'h0002
// monitor registers
`define DSM_ADDR_OUT_STAT 16'h002d
`define DSM_ADDR_DC_BUS   16'h0031
`define DSM_ADDR_TORQUE   16'h0032
`define DSM_ADDR_OUT_PWR  16'h0033
`define DSM_ADDR_PID_FB   16'h0038
`define DSM_ADDR_PID_IN   16'h0039
`define DSM_ADDR_PID_OUT  16'h003a
`define DSM_ADDR_CPU_VER  16'h003b
`define DSM_ADDR_FLASH    16'h003c
`define DSM_ADDR_ERR      16'h003d
`define DSM_ADDR_KVA      16'h003e
`define DSM_ADDR_CTRL     16'h003f

// operation command word fields
`define DSM_BIT_RUN      0
`define DSM_BIT_REVERSE  1
`define DSM_BIT_EXT_FLT  4
`define DSM_BIT_FLT_RST  5
`define DSM_BIT_MI_FIVE  12
`define DSM_BIT_MI_EIGHT 15
`define DSM_OP_DEF_MASK  16'hf033

// error detail fields
`define DSM_ERR_CRC   0
`define DSM_ERR_LEN   1
`define DSM_ERR_PAR   3
`define DSM_ERR_OVR   4
`define DSM_ERR_FRM   5
`define DSM_ERR_TMO   6

// reset values and scaling
`define DSM_RST_OP_CMD   16'h0000
`define DSM_RST_FREQ_REF 16'h0000
`define DSM_FREF_FULL    16'h7530
`define DSM_FREF_DIV     16'h001e
`define DSM_PCT_POS      16'h03e8
`define DSM_PCT_NEG      16'hfc18

`endif

// ---- logic/dsm_pkg.sv ----
// shared types of the drive serial monitor register bank
package dsm_pkg;
	// answer code of one register access
	typedef enum logic [1:0] {
		DSM_RESP_OK        = 2'b00,
		DSM_RESP_BAD_ADDR  = 2'b01,
		DSM_RESP_READ_ONLY = 2'b10
	} dsm_resp_t;
	// one register word
	typedef logic [15:0] dsm_word_t;
endpackage : dsm_pkg

// ---- logic/dsm_err_if.sv ----
// carrier between the bank and its error detail latch
`timescale 1ns/10ps
interface dsm_err_if;
	logic [15:0] evt;    // one-cycle error events per bit
	logic        clr;    // fault reset level
	logic [15:0] detail; // latched error details
	modport src (output evt, output clr, input detail);
	modport sink (input evt, input clr, output detail);
endinterface : dsm_err_if

// ---- logic/dsm_sync.sv ----
// two flip-flop synchroniser for pin inputs, one stage pair per bit
`timescale 1ns/10ps
module dsm_sync #(
	parameter int WIDTH = 6
) (
	input  logic             i_clock,
	input  logic             i_srst,
	input  logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_q; // first stage, read only by second
	genvar g;
	// per-bit double flop
	for (g = 0; g < WIDTH; g++) begin : g_bit
		always_ff @(posedge i_clock) begin
			if (i_srst) begin
				meta_q[g] <= 1'b0;
				o_sync[g] <= 1'b0;
			end else begin
				meta_q[g] <= i_async[g];
				o_sync[g] <= meta_q[g];
			end
		end
	end
endmodule : dsm_sync

// ---- logic/dsm_err_latch.sv ----
// sticky communications error detail bits
`timescale 1ns/10ps
module dsm_err_latch (
	input  logic   i_clock,
	input  logic   i_srst,
	dsm_err_if.sink err
);
	genvar g;
	// per-bit latch, set wins over clear
	for (g = 0; g < 16; g++) begin : g_bit
		always_ff @(posedge i_clock) begin
			if (i_srst) begin
				err.detail[g] <= 1'b0;
			end else if (err.evt[g]) begin
				err.detail[g] <= 1'b1;
			end else if (err.clr) begin
				err.detail[g] <= 1'b0;
			end
		end
	end
endmodule : dsm_err_latch

// ---- verification/dsm_regs_props.sv ----
// concurrent checks on the register bank ports
`timescale 1ns/10ps
`include "dsm_map.svh"
module dsm_regs_props (
	input logic        i_clock,
	input logic        i_srst,
	input logic        i_reg_sel,
	input logic        i_reg_write,
	input logic [15:0] i_reg_addr,
	input logic [15:0] i_reg_wdata,
	input logic        o_reg_done,
	input logic [15:0] i_local_cmd,
	input logic        i_crc_err,
	input logic        i_len_err,
	input logic        i_parity_err,
	input logic        i_overrun_err,
	input logic        i_framing_err,
	input logic        i_timeout_err,
	input logic        o_run,
	input logic        o_reverse,
	input logic        o_ext_fault,
	input logic        o_fault_reset,
	input logic [3:0]  o_multi_inputs,
	input logic [15:0] o_effective_cmd,
	input logic [15:0] o_freq_ref_pct,
	input logic [15:0] o_link_error_details
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_srst);
	// write strobes of the two broadcast words
	wire op_wr = i_reg_sel & i_reg_write & (i_reg_addr == `DSM_ADDR_OP_CMD);
	wire fr_wr = i_reg_sel & i_reg_write & (i_reg_addr == `DSM_ADDR_FREQ_REF);
	logic [15:0] ev;   // error events placed on their detail bits
	logic [15:0] fexp; // scaled reference of the word being written
	assign ev = {9'h000, i_timeout_err, i_framing_err, i_overrun_err, i_parity_err,
		1'b0, i_len_err, i_crc_err};
	assign fexp = ((i_reg_wdata > `DSM_FREF_FULL) ? `DSM_FREF_FULL : i_reg_wdata)
		/ `DSM_FREF_DIV;
	////////////////////////////////////////////////////////////////////////
	AST_DONE: assert property (i_reg_sel |=> o_reg_done)
		else $error("access not answered");
	AST_RUN: assert property (op_wr |-> ##2 o_run == $past(i_reg_wdata[0], 2))
		else $error("run does not follow command");
	AST_REV: assert property (op_wr |-> ##2 o_reverse == $past(i_reg_wdata[1], 2))
		else $error("direction does not follow command");
	AST_EXTF: assert property (op_wr |-> ##2 o_ext_fault == $past(i_reg_wdata[4], 2))
		else $error("external fault does not follow command");
	AST_FRST: assert property (op_wr && i_reg_wdata[5] |-> ##2 o_fault_reset)
		else $error("fault reset not issued");
	AST_MI: assert property (op_wr |-> ##2 o_multi_inputs == $past(i_reg_wdata[15:12], 2))
		else $error("multi inputs do not follow command");
	AST_LOCAL: assert property (
		(o_effective_cmd & ~`DSM_OP_DEF_MASK) == ($past(i_local_cmd) & ~`DSM_OP_DEF_MASK))
		else $error("undefined bits not from local word");
	AST_ERRSET: assert property (
		ev != 0 |-> ##2 (o_link_error_details & $past(ev, 2)) == $past(ev, 2))
		else $error("error detail bit not set");
	AST_ERRHOLD: assert property (
		($past(o_link_error_details) & ~o_link_error_details) != 0
		|-> o_fault_reset || $past(o_fault_reset) || $past(o_fault_reset, 2))
		else $error("error detail dropped without fault reset");
	AST_FREF: assert property (fr_wr |-> ##2 o_freq_ref_pct == $past(fexp, 2))
		else $error("reference scaling wrong");
	// main scenarios reached
	cover property (op_wr);
	cover property (fr_wr);
	cover property (ev != 0);
endmodule : dsm_regs_props

bind dsm_regs dsm_regs_props chk (.i_clock, .i_srst, .i_reg_sel, .i_reg_write, .i_reg_addr,
	.i_reg_wdata, .o_reg_done, .i_local_cmd, .i_crc_err, .i_len_err, .i_parity_err,
	.i_overrun_err, .i_framing_err, .i_timeout_err, .o_run, .o_reverse, .o_ext_fault,
	.o_fault_reset, .o_multi_inputs, .o_effective_cmd, .o_freq_ref_pct, .o_link_error_details);

// ---- verification/dsm_plc_master.sv ----
// serial master model: one register access at a time
`timescale 1ns/10ps
module dsm_plc_master (
	input  logic        i_clock,
	input  logic        i_done,
	input  logic [15:0] i_rdata,
	input  logic [1:0]  i_resp,
	output logic        o_sel,
	output logic        o_write,
	output logic [15:0] o_addr,
	output logic [15:0] o_wdata
);
	// idle request lines
	initial begin
		o_sel = 1'b0;
		o_write = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end
	// request at a falling edge, held until the answer is seen or eight cycles pass
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic [15:0] rd, output logic [1:0] rs);
		int n;
		n = 0;
		@(negedge i_clock);
		o_sel = 1'b1;
		o_write = w;
		o_addr = a;
		o_wdata = d;
		do begin
			@(negedge i_clock);
			n++;
		end while (i_done !== 1'b1 && n < 8);
		// an access never answered hands back unknowns, which every compare flags
		rd = (i_done === 1'b1) ? i_rdata : 16'hxxxx;
		rs = (i_done === 1'b1) ? i_resp : 2'hx;
		o_sel = 1'b0;
		// released lines show no stale value
		o_addr = ~a;
		o_wdata = ~d;
	endtask : acc
endmodule : dsm_plc_master

// ---- verification/drive_serial_monitor_broadcast_regs_bench.sv ----
// self-checking bench of the register bank
`timescale 1ns/10ps
`include "dsm_map.svh"
module drive_serial_monitor_broadcast_regs_bench
	import dsm_pkg::*;
();
	logic        i_clock = 1'b0;
	logic        i_srst = 1'b1;
	logic        i_reg_sel, i_reg_write, o_reg_done;
	logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rd;
	logic [1:0]  o_reg_resp, rs;
	logic        o_run, o_reverse, o_ext_fault, o_fault_reset;
	logic [3:0]  o_multi_inputs;
	logic [15:0] o_effective_cmd, o_freq_ref_pct, o_link_error_details;
	logic [15:0] i_local_cmd = 16'h0000;
	logic [15:0] mon = 16'h1234; // base of pass-through monitors
	logic [15:0] fb = 16'h0000;  // raw feedback
	logic [15:0] pid = 16'h0000; // raw pid in and out
	logic [4:0]  pins = 5'h00;   // terminal outputs
	logic [5:0]  ev = 6'h00;     // error pulses
	logic        fpin = 1'b0;    // fault reset pin
	int          miscompares = 0;
	int          compares = 0;
	always #5 i_clock = ~i_clock;
	dsm_regs uut (.i_clock, .i_srst, .i_reg_sel, .i_reg_write, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .o_reg_done, .o_reg_resp, .i_local_cmd, .i_contact_out_one(pins[0]),
		.i_contact_out_two(pins[1]), .i_contact_out_three(pins[2]),
		.i_photocoupler_out_three(pins[3]), .i_photocoupler_out_four(pins[4]),
		.i_fault_reset_pin(fpin), .i_dc_bus_voltage(mon ^ 16'h0031),
		.i_torque(mon ^ 16'h0032), .i_output_power_monitor(mon ^ 16'h0033),
		.i_pid_feedback(fb), .i_pid_input(pid), .i_pid_output(pid),
		.i_cpu_version(mon ^ 16'h003b), .i_flash_version(mon ^ 16'h003c),
		.i_power_rating(mon ^ 16'h003e), .i_control_scheme(mon ^ 16'h003f),
		.i_crc_err(ev[0]), .i_len_err(ev[1]), .i_parity_err(ev[2]), .i_overrun_err(ev[3]),
		.i_framing_err(ev[4]), .i_timeout_err(ev[5]), .o_run, .o_reverse, .o_ext_fault,
		.o_fault_reset, .o_multi_inputs, .o_effective_cmd, .o_freq_ref_pct,
		.o_link_error_details);
	dsm_plc_master plc (.i_clock, .i_done(o_reg_done), .i_rdata(o_reg_rdata),
		.i_resp(o_reg_resp), .o_sel(i_reg_sel), .o_write(i_reg_write), .o_addr(i_reg_addr),
		.o_wdata(i_reg_wdata));
	////////////////////////////////////////////////////////////////////////
	// compare and count
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// write expecting an accepted answer
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		plc.acc(1'b1, a, d, rd, rs);
		check("write resp", 16'(rs), 16'(DSM_RESP_OK));
	endtask : wr
	// read expecting a value and an accepted answer
	task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string what);
		plc.acc(1'b0, a, 16'h0000, rd, rs);
		check(what, rd, exp);
		check("read resp", 16'(rs), 16'(DSM_RESP_OK));
	endtask : rd_chk
	// command bits reach outputs, other bits come from the local word
	task automatic t_cmd();
		logic [15:0] v[5];
		v = '{16'h0001, 16'h0002, 16'h0010, 16'h5000, 16'ha023};
		foreach (v[i]) begin
			wr(`DSM_ADDR_OP_CMD, v[i]);
			@(negedge i_clock);
			check("effective", o_effective_cmd, (v[i] & 16'hf033) | (i_local_cmd & 16'h0fcc));
			check("run", 16'(o_run), 16'(v[i][0]));
			check("reverse", 16'(o_reverse), 16'(v[i][1]));
			check("ext fault", 16'(o_ext_fault), 16'(v[i][4]));
			check("fault reset", 16'(o_fault_reset), 16'(v[i][5]));
			check("multi", 16'(o_multi_inputs), 16'(v[i][15:12]));
			rd_chk(`DSM_ADDR_OP_CMD, v[i], "op word");
		end
	endtask : t_cmd
	// reference scaling and clipping
	task automatic t_fref();
		logic [15:0] v[4];
		logic [15:0] e[4];
		v = '{16'h7530, 16'hffff, 16'h001d, 16'h3a98};
		e = '{16'h03e8, 16'h03e8, 16'h0000, 16'h01f4};
		foreach (v[i]) begin
			wr(`DSM_ADDR_FREQ_REF, v[i]);
			@(negedge i_clock);
			check("freq ref", o_freq_ref_pct, e[i]);
		end
	endtask : t_fref
	// terminal outputs seen in the status word
	task automatic t_stat();
		for (int i = 1; i < 4; i++) begin
			pins = 5'(1 << i);
			repeat (3) @(negedge i_clock);
			rd_chk(`DSM_ADDR_OUT_STAT, 16'(1 << i), "status");
		end
	endtask : t_stat
	// sticky error details, cleared by command while running and by the pin
	task automatic t_err();
		int pos[6];
		logic [15:0] e;
		pos = '{0, 1, 3, 4, 5, 6};
		e = 16'h0000;
		// drop the fault reset left by the command scenario, or it wipes every new bit
		wr(`DSM_ADDR_OP_CMD, 16'h0000);
		foreach (pos[i]) begin
			ev = 6'(1 << i);
			@(negedge i_clock);
			ev = 6'h00;
			repeat (2) @(negedge i_clock);
			e = e | 16'(1 << pos[i]);
			check("details", o_link_error_details, e);
		end
		rd_chk(`DSM_ADDR_ERR, 16'h007b, "detail word");
		wr(`DSM_ADDR_OP_CMD, 16'h0021);
		wr(`DSM_ADDR_OP_CMD, 16'h0001);
		rd_chk(`DSM_ADDR_ERR, 16'h0000, "cleared running");
		check("still running", 16'(o_run), 16'h0001);
		ev = 6'h01;
		@(negedge i_clock);
		ev = 6'h00;
		@(negedge i_clock);
		check("set again", o_link_error_details, 16'h0001);
		fpin = 1'b1;
		repeat (4) @(negedge i_clock);
		check("pin reset", 16'(o_fault_reset), 16'h0001);
		fpin = 1'b0;
		repeat (4) @(negedge i_clock);
		check("pin cleared", o_link_error_details, 16'h0000);
	endtask : t_err
	// monitors, pid scaling and refused accesses
	task automatic t_mon();
		logic [15:0] a[7];
		a = '{16'h0031, 16'h0032, 16'h0033, 16'h003b, 16'h003c, 16'h003e, 16'h003f};
		fb = 16'h0500;
		pid = 16'hfc00;
		foreach (a[i]) rd_chk(a[i], mon ^ a[i], "monitor");
		rd_chk(`DSM_ADDR_PID_FB, 16'h03e8, "pid fb high");
		rd_chk(`DSM_ADDR_PID_IN, 16'hfc18, "pid in low");
		fb = 16'hff00;
		pid = 16'h0200;
		rd_chk(`DSM_ADDR_PID_FB, 16'h0000, "pid fb neg");
		rd_chk(`DSM_ADDR_PID_OUT, 16'h0200, "pid out");
		plc.acc(1'b1, `DSM_ADDR_ERR, 16'hffff, rd, rs);
		check("ro resp", 16'(rs), 16'(DSM_RESP_READ_ONLY));
		plc.acc(1'b0, 16'h0000, 16'h0000, rd, rs);
		check("bad resp", 16'(rs), 16'(DSM_RESP_BAD_ADDR));
	endtask : t_mon
	// verdict and end of run
	task automatic complete_run();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	// main sequence
	initial begin
		repeat (10) @(negedge i_clock);
		i_srst = 1'b0;
		repeat (2) @(negedge i_clock);
		i_local_cmd = 16'h5aa5;
		@(negedge i_clock);
		t_cmd();
		t_fref();
		t_stat();
		t_err();
		t_mon();
		complete_run();
	end
	// watchdog
	initial begin
		#100000;
		miscompares++;
		complete_run();
	end
endmodule : drive_serial_monitor_broadcast_regs_bench
